// ---- hw/tfab_regs.svh ----
/*
  Register offsets, field positions, reset values and widths of the timer
  flag and bus access block. Word addresses on a 16-bit register port.
  Assumes nothing; definitions only.
*/
`ifndef TFAB_REGS_SVH
`define TFAB_REGS_SVH

// Word addresses
`define TFAB_A_STATUS    5'h00
`define TFAB_A_IRQ_STAT  5'h01
`define TFAB_A_IRQ_MASK  5'h02
`define TFAB_A_CNT0_HI   5'h03
`define TFAB_A_CNT0_LO   5'h04
`define TFAB_A_CAP_HI    5'h05
`define TFAB_A_CAP_LO    5'h06
`define TFAB_A_CNT1      5'h07
`define TFAB_A_GEN       5'h08
`define TFAB_A_OCR       5'h09
`define TFAB_A_CYCLE     5'h0a
`define TFAB_A_OFFSET_BASE_REG      5'h0b
`define TFAB_A_DOWN_COUNTER      5'h0c
`define TFAB_A_START12   5'h0d
`define TFAB_A_START3    5'h0e
`define TFAB_A_PRESC     5'h0f
`define TFAB_A_ITV       5'h10

// Byte lane enables
`define TFAB_BE_WORD     2'h3
`define TFAB_BE_UPPER    2'h2
`define TFAB_BE_LOWER    2'h1

// Status bit positions
`define TFAB_ST_CAP      0
`define TFAB_ST_CMF      1
`define TFAB_ST_IMF      2
`define TFAB_ST_OVF      3
`define TFAB_ST_UDF      4
`define TFAB_ST_ITV      5
`define TFAB_ST_CYC      6
`define TFAB_NFLAGS      7

// Start bit positions
`define TFAB_START_CNT0  0
`define TFAB_START_CNT1  1
`define TFAB_START_DOWN_COUNTER  0

// Interval tap bits of counter zero
`define TFAB_ITV_LSB     10
`define TFAB_ITV_MSB     13

// Reset values and the counter one maximum
`define TFAB_RST_W16     16'h0000
`define TFAB_RST_W32     32'h00000000
`define TFAB_RST_B8      8'h00
`define TFAB_RST_CMP     16'hffff
`define TFAB_CNT1_MAX    16'hffff

`endif

// ---- hw/tfab_pkg.sv ----
/*
  Types of the timer flag and bus access block: the packed state records
  of each module. Assumes tfab_regs.svh is on the include path.
*/
`include "tfab_regs.svh"

package tfab_pkg;

  typedef logic [`TFAB_NFLAGS-1:0] tfab_flags_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic [31:0] cnt0;
    logic [15:0] cnt1;
    logic [31:0] cap;
    logic [15:0] gen;
    logic [15:0] output_compare_reg;
    logic [15:0] cyc;
    logic [15:0] offset_base_reg;
    logic [15:0] rd_buf;
    logic [15:0] wr_buf;
    logic [7:0]  presc;
    logic [7:0]  presc_cnt;
    logic [3:0]  itv_en;
    logic [7:0]  start1;
    logic [7:0]  start2;
    logic [7:0]  start3;
    tfab_flags_t status;
    tfab_flags_t armed;
    tfab_flags_t irq_stat;
    tfab_flags_t irq_mask;
    logic [1:0]  dma_pend;
    logic        match;
    logic        dma_req;
  } tfab_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        stepped;
    logic        clr_pend;
    logic        set_uf;
    logic        clr_uf;
  } tfab_down_counter_state_t;

  typedef struct packed {
    logic [2:0] sync;
    logic       stable;
    logic       rise;
  } tfab_sync_state_t;

endpackage

// ---- hw/tfab_pin_sync.sv ----
/*
  Three flip-flop pin synchroniser with a rising-edge pulse.
  Assumes an asynchronous pin; output is on i_clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tfab_pin_sync (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // Pin
  input  wire logic i_pin,
  // Synchronised outputs
  output logic      o_level,
  output logic      o_rise
);

  tfab_pkg::tfab_sync_state_t st_ff;
  tfab_pkg::tfab_sync_state_t nxt_st;

  // Level counts only once stages two and three agree
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.sync = {st_ff.sync[1:0], i_pin};
    nxt_st.rise = 1'b0;
    if (st_ff.sync[1] == st_ff.sync[2]) begin
      nxt_st.stable = st_ff.sync[2];
      nxt_st.rise   = st_ff.sync[2] & ~st_ff.stable;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_level = st_ff.stable;
  assign o_rise  = st_ff.rise;

endmodule // tfab_pin_sync

`default_nettype wire

// ---- hw/tfab_down_counter.sv ----
/*
  One-shot down-counter with underflow set and forced-clear reporting.
  Assumes i_tick is a one-cycle enable from the block's prescaler.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tfab_regs.svh"

module tfab_down_counter (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Control
  input  wire logic        i_tick,
  input  wire logic        i_load,
  input  wire logic [15:0] i_load_val,
  input  wire logic        i_force_clr,
  // Status
  output logic      [15:0] o_count,
  output logic             o_set_uf,
  output logic             o_clr_uf
);

  tfab_pkg::tfab_down_counter_state_t st_ff;
  tfab_pkg::tfab_down_counter_state_t nxt_st;

  // Count, hold at zero, and report underflow one tick late
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.set_uf = 1'b0;
    nxt_st.clr_uf = 1'b0;
    if (i_force_clr) begin
      nxt_st.cnt      = `TFAB_RST_W16;
      nxt_st.stepped  = 1'b0;
      nxt_st.clr_pend = 1'b1;
    end else if (i_load) begin
      nxt_st.cnt      = i_load_val;
      nxt_st.stepped  = 1'b0;
    end else if (i_tick) begin
      if (st_ff.clr_pend) begin
        nxt_st.clr_uf   = 1'b1;
        nxt_st.clr_pend = 1'b0;
      end
      if (st_ff.cnt == 16'h0001) begin
        nxt_st.cnt     = `TFAB_RST_W16;
        nxt_st.stepped = 1'b1;
      end else if (st_ff.cnt == `TFAB_RST_W16) begin
        // Zero holds; never wraps below it
        nxt_st.cnt = `TFAB_RST_W16;
        if (st_ff.stepped) begin
          nxt_st.set_uf  = 1'b1;
          nxt_st.stepped = 1'b0;
        end
      end else begin
        nxt_st.cnt = st_ff.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_count  = st_ff.cnt;
  assign o_set_uf = st_ff.set_uf;
  assign o_clr_uf = st_ff.clr_uf;

endmodule // tfab_down_counter

`default_nettype wire

// ---- hw/tfab_core.sv ----
/*
  Timer status flags and 16-bit CPU register access: counters, capture,
  compare, down-counter, interval flag, split 32-bit access, byte lanes.
  Assumes a one-cycle strobe master on i_clock and an asynchronous pin.
*/
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tfab_regs.svh"

module tfab_core (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [4:0]  i_addr,
  input  wire logic [1:0]  i_be,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Capture pin
  input  wire logic        i_capture_pin,
  // DMA controller
  output logic             o_dma_req,
  input  wire logic        i_dma_clr_capture,
  input  wire logic        i_dma_clr_match,
  // Events and interrupt
  output logic             o_compare_match,
  output logic             o_irq
);

  tfab_pkg::tfab_state_t st_ff;
  tfab_pkg::tfab_state_t nxt_st;

  logic        cap_rise;
  logic [15:0] down_counter_val;
  logic        down_counter_set_uf;
  logic        down_counter_clr_uf;
  logic        tick;
  logic        tick0;
  logic        tick1;
  logic        gen_match;
  logic        ocr_match;
  logic        cyc_match;
  logic        wr_word;
  logic        wr_up;
  logic        wr_lo;
  logic        down_counter_load;
  logic [3:0]  itv_field;
  logic [3:0]  itv_rise;
  logic        itv_carry;
  logic        irq_rd;

  tfab_pkg::tfab_flags_t set_ev;
  tfab_pkg::tfab_flags_t clr_sw;
  tfab_pkg::tfab_flags_t clr_dma;

  // Set wins over clear on every hardware flag
  function automatic tfab_pkg::tfab_flags_t flag_next(
    input tfab_pkg::tfab_flags_t cur,
    input tfab_pkg::tfab_flags_t set,
    input tfab_pkg::tfab_flags_t clr
  );
    flag_next = (cur & ~clr) | set;
  endfunction

  // Byte lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(
    input logic [15:0] cur,
    input logic [15:0] wd,
    input logic [1:0]  be
  );
    lane_merge = {be[1] ? wd[15:8] : cur[15:8],
                  be[0] ? wd[7:0]  : cur[7:0]};
  endfunction

  // Match seen only on the tick that steps the counter off the value
  function automatic logic step_match(
    input logic        tk,
    input logic [15:0] cnt,
    input logic [15:0] ref_val
  );
    step_match = tk & (cnt == ref_val);
  endfunction

  // Capture pin through the three-stage synchroniser
  tfab_pin_sync u_cap_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_pin   (i_capture_pin),
    .o_level (),
    .o_rise  (cap_rise)
  );

  // One-shot down-counter, cut off by a general register match
  tfab_down_counter u_down_counter (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_tick      (tick & st_ff.start3[`TFAB_START_DOWN_COUNTER]),
    .i_load      (down_counter_load),
    .i_load_val  (i_wdata),
    .i_force_clr (gen_match),
    .o_count     (down_counter_val),
    .o_set_uf    (down_counter_set_uf),
    .o_clr_uf    (down_counter_clr_uf)
  );

  // Prescaler tick and per-counter start gating
  assign tick  = (st_ff.presc_cnt == st_ff.presc);
  assign tick0 = tick & st_ff.start1[`TFAB_START_CNT0];
  assign tick1 = tick & st_ff.start1[`TFAB_START_CNT1];

  // Matches count only as the counter steps away from the value
  assign gen_match = step_match(tick1, st_ff.cnt1, st_ff.gen);
  assign ocr_match = step_match(tick1, st_ff.cnt1, st_ff.output_compare_reg);
  assign cyc_match = step_match(tick1, st_ff.cnt1, st_ff.cyc);

  // Lane qualifiers; partial writes to word registers are dropped
  assign wr_word   = i_wr & (i_be == `TFAB_BE_WORD);
  assign wr_up     = i_wr & (i_be == `TFAB_BE_UPPER);
  assign wr_lo     = i_wr & (i_be != 2'h0);
  assign down_counter_load = wr_word & (i_addr == `TFAB_A_DOWN_COUNTER);

  // Interval taps rise only when the carry out of bit 9 reaches them
  assign itv_field = st_ff.cnt0[`TFAB_ITV_MSB:`TFAB_ITV_LSB];
  assign itv_carry = &st_ff.cnt0[`TFAB_ITV_LSB-1:0];
  assign itv_rise  = (itv_field + 4'h1) & ~itv_field & {4{itv_carry}};

  // Reading the interrupt status clears it
  assign irq_rd = i_rd & (i_addr == `TFAB_A_IRQ_STAT);

  // Flag set events from counters, capture and down-counter
  always_comb begin
    set_ev = '0;
    set_ev[`TFAB_ST_CAP] = cap_rise;
    set_ev[`TFAB_ST_IMF] = cap_rise | gen_match | ocr_match;
    set_ev[`TFAB_ST_CMF] = gen_match | ocr_match;
    set_ev[`TFAB_ST_CYC] = cyc_match;
    // Through a cycle match the counter restarts; not a wrap
    set_ev[`TFAB_ST_OVF] = (tick1 & ~cyc_match &
                            (st_ff.cnt1 == `TFAB_CNT1_MAX)) |
                           (tick0 & (&st_ff.cnt0));
    set_ev[`TFAB_ST_UDF] = down_counter_set_uf;
    set_ev[`TFAB_ST_ITV] = tick0 & (|(itv_rise & st_ff.itv_en));
  end

  // Software clear needs an armed bit and a 0 written to it
  always_comb begin
    clr_sw = '0;
    if (wr_word && (i_addr == `TFAB_A_STATUS)) begin
      // A 1 written leaves the bit and its arming alone
      clr_sw = st_ff.armed & ~i_wdata[`TFAB_NFLAGS-1:0];
    end
    clr_sw[`TFAB_ST_UDF] = clr_sw[`TFAB_ST_UDF] | down_counter_clr_uf;
  end

  // DMA clear honoured only for a request this block raised
  always_comb begin
    clr_dma = '0;
    clr_dma[`TFAB_ST_CAP] = i_dma_clr_capture & st_ff.dma_pend[0];
    clr_dma[`TFAB_ST_CMF] = i_dma_clr_match & st_ff.dma_pend[1];
  end

  // Next state of the whole block
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.match   = ocr_match | gen_match;
    nxt_st.dma_req = cap_rise | ocr_match;
    nxt_st.rdata   = `TFAB_RST_W16;

    // Prescaler divider
    nxt_st.presc_cnt = tick ? `TFAB_RST_B8 : st_ff.presc_cnt + 8'h01;

    // Counters; cycle match restarts counter one
    if (tick0) begin
      nxt_st.cnt0 = st_ff.cnt0 + 32'h00000001;
    end
    if (cyc_match) begin
      nxt_st.cnt1 = `TFAB_RST_W16;
    end else if (tick1) begin
      nxt_st.cnt1 = st_ff.cnt1 + 16'h0001;
    end

    // Capture copies both counters in the same cycle
    if (cap_rise) begin
      nxt_st.cap  = st_ff.cnt0;
      nxt_st.gen  = st_ff.cnt1;
      nxt_st.offset_base_reg = st_ff.cnt1;
    end

    // Flags, arming and DMA pending
    nxt_st.status   = flag_next(st_ff.status, set_ev, clr_sw | clr_dma);
    nxt_st.armed    = st_ff.armed & ~clr_sw;
    // Pending until cleared, so a stray clear is ignored
    nxt_st.dma_pend = (st_ff.dma_pend & ~{i_dma_clr_match,
                                          i_dma_clr_capture}) |
                      {ocr_match, cap_rise};

    // Register reads
    if (i_rd) begin
      case (i_addr)
        `TFAB_A_STATUS: begin
          nxt_st.rdata = {9'h000, st_ff.status};
          nxt_st.armed = st_ff.status;
        end
        `TFAB_A_IRQ_STAT: nxt_st.rdata = {9'h000, st_ff.irq_stat};
        `TFAB_A_IRQ_MASK: nxt_st.rdata = {9'h000, st_ff.irq_mask};
        // One read buffer serves counter zero and capture
        `TFAB_A_CNT0_HI: begin
          nxt_st.rdata  = st_ff.cnt0[31:16];
          nxt_st.rd_buf = st_ff.cnt0[15:0];
        end
        `TFAB_A_CNT0_LO: nxt_st.rdata = st_ff.rd_buf;
        `TFAB_A_CAP_HI: begin
          nxt_st.rdata  = st_ff.cap[31:16];
          nxt_st.rd_buf = st_ff.cap[15:0];
        end
        `TFAB_A_CAP_LO:  nxt_st.rdata = st_ff.rd_buf;
        `TFAB_A_CNT1:    nxt_st.rdata = st_ff.cnt1;
        `TFAB_A_GEN:     nxt_st.rdata = st_ff.gen;
        `TFAB_A_OCR:     nxt_st.rdata = st_ff.output_compare_reg;
        `TFAB_A_CYCLE:   nxt_st.rdata = st_ff.cyc;
        `TFAB_A_OFFSET_BASE_REG:    nxt_st.rdata = st_ff.offset_base_reg;
        `TFAB_A_DOWN_COUNTER:    nxt_st.rdata = down_counter_val;
        `TFAB_A_START12: nxt_st.rdata = {st_ff.start1, st_ff.start2};
        `TFAB_A_START3:  nxt_st.rdata = {st_ff.start3, 8'h00};
        `TFAB_A_PRESC:   nxt_st.rdata = {st_ff.presc, 8'h00};
        `TFAB_A_ITV:     nxt_st.rdata = {4'h0, st_ff.itv_en, 8'h00};
        default:         nxt_st.rdata = `TFAB_RST_W16;
      endcase
    end

    // Register writes; capture and offset base have no write path
    if (i_wr) begin
      case (i_addr)
        `TFAB_A_IRQ_MASK: begin
          if (wr_word) begin
            nxt_st.irq_mask = i_wdata[`TFAB_NFLAGS-1:0];
          end
        end
        `TFAB_A_CNT0_HI: begin
          if (wr_word) begin
            nxt_st.wr_buf = i_wdata;
          end
        end
        `TFAB_A_CNT0_LO: begin
          if (wr_word) begin
            // Both halves at once, over any count this cycle
            nxt_st.cnt0 = {st_ff.wr_buf, i_wdata};
          end
        end
        `TFAB_A_CNT1: begin
          if (wr_word) begin
            nxt_st.cnt1 = i_wdata;
          end
        end
        `TFAB_A_GEN: begin
          if (wr_word && !cap_rise) begin
            nxt_st.gen = i_wdata;
          end
        end
        `TFAB_A_OCR: begin
          if (wr_word) begin
            nxt_st.output_compare_reg = i_wdata;
          end
        end
        `TFAB_A_CYCLE: begin
          if (wr_word) begin
            nxt_st.cyc = i_wdata;
          end
        end
        `TFAB_A_START12: begin
          if (wr_lo) begin
            // Either lane alone, or both as one word
            {nxt_st.start1, nxt_st.start2} =
              lane_merge({st_ff.start1, st_ff.start2}, i_wdata,
                         i_be);
          end
        end
        // Second half of a split start write; lands later
        `TFAB_A_START3: begin
          if (wr_up) begin
            nxt_st.start3 = i_wdata[15:8];
          end
        end
        `TFAB_A_PRESC: begin
          if (wr_up) begin
            nxt_st.presc = i_wdata[15:8];
          end
        end
        `TFAB_A_ITV: begin
          if (wr_up) begin
            nxt_st.itv_en = i_wdata[11:8];
          end
        end
        default: begin
          // Unmapped and read-only addresses drop writes
        end
      endcase
    end

    // Interrupt status: sticky, cleared by its read, set wins
    nxt_st.irq_stat = flag_next(st_ff.irq_stat, set_ev,
                                {`TFAB_NFLAGS{irq_rd}});
  end

  // Single state register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_ff     <= '0;
      st_ff.gen <= `TFAB_RST_CMP;
      st_ff.output_compare_reg <= `TFAB_RST_CMP;
      st_ff.cyc <= `TFAB_RST_CMP;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign o_rdata         = st_ff.rdata;
  assign o_dma_req       = st_ff.dma_req;
  assign o_compare_match = st_ff.match;
  assign o_irq           = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule // tfab_core

`default_nettype wire

// ---- dv/tfab_core_checker.sv ----
/*
  Port checker for tfab_core, bound into every instance of it.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module tfab_core_checker (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst,
  // Register port
  input wire logic [4:0]  i_addr,
  input wire logic [1:0]  i_be,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  // Pin, DMA and events
  input wire logic        i_capture_pin,
  input wire logic        o_dma_req,
  input wire logic        i_dma_clr_capture,
  input wire logic        i_dma_clr_match,
  input wire logic        o_compare_match,
  input wire logic        o_irq
);
  logic rd_unmap, rd_flag, rd_upper, rd_itv, irq_clr;

  // Read kinds, decoded one cycle ahead of their data
  assign rd_unmap = i_rd && (i_addr > 5'h10);
  assign rd_flag  = i_rd && (i_addr <= 5'h02);
  assign rd_upper = i_rd && (i_addr == 5'h0e || i_addr == 5'h0f);
  assign rd_itv   = i_rd && (i_addr == 5'h10);
  // Only these accesses may drop the interrupt
  assign irq_clr  = (i_rd && i_addr == 5'h01) || (i_wr && i_addr == 5'h02);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (
    $past(rd_unmap) |-> o_rdata == 16'h0000)
    else $error("unmapped read returned data");
  flag_bits_a: assert property (
    $past(rd_flag) |-> o_rdata[15:7] == 9'h000)
    else $error("flag register shows bits above the flags");
  upper_lane_a: assert property (
    $past(rd_upper) |-> o_rdata[7:0] == 8'h00)
    else $error("byte register data on the lower lane");
  itv_field_a: assert property (
    $past(rd_itv) |-> o_rdata[15:12] == 4'h0 && o_rdata[7:0] == 8'h00)
    else $error("interval enable read outside its field");
  dma_pulse_a: assert property (
    o_dma_req |=> !o_dma_req)
    else $error("transfer request longer than one cycle");
  capture_dma_a: assert property (
    $rose(i_capture_pin) |-> ##[1:8] o_dma_req)
    else $error("capture did not request a transfer");
  irq_fall_a: assert property (
    $fell(o_irq) |-> $past(irq_clr) || $past(irq_clr, 2))
    else $error("interrupt dropped without a clearing access");
endmodule // tfab_core_checker

bind tfab_core tfab_core_checker tfab_core_checker_i (
  .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_be(i_be),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_capture_pin(i_capture_pin), .o_dma_req(o_dma_req),
  .i_dma_clr_capture(i_dma_clr_capture),
  .i_dma_clr_match(i_dma_clr_match),
  .o_compare_match(o_compare_match), .o_irq(o_irq)
);

`default_nettype wire

// ---- dv/tfab_dma_model.sv ----
/*
  Behavioural DMA controller: answers a transfer request with one
  flag clear pulse after a fixed delay; a new request restarts the wait.
  Assumes the request is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tfab_dma_model #(
  parameter int DELAY = 8
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // Request side
  input  wire logic i_dma_req,
  input  wire logic i_sel,
  // Clear pulses
  output var  logic o_clr_capture,
  output var  logic o_clr_match
);
  logic [3:0] wait_ff;

  // Clear lands mid-transfer, so the flag is seen set for a while first
  always_ff @(posedge i_clock) begin
    o_clr_capture <= 1'h0;
    o_clr_match   <= 1'h0;
    if (i_rst) begin
      wait_ff <= 4'h0;
    end else if (i_dma_req) begin
      wait_ff <= 4'(DELAY);
    end else if (wait_ff != 4'h0) begin
      wait_ff <= wait_ff - 4'h1;
      if (wait_ff == 4'h1) begin
        o_clr_capture <= !i_sel;
        o_clr_match   <= i_sel;
      end
    end
  end
endmodule // tfab_dma_model

`default_nettype wire

// ---- dv/timer_flag_and_bus_access_test.sv ----
/*
  Self-checking bench for tfab_core with a DMA model on its request.
  Assumes tfab_regs.svh on the include path; 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tfab_regs.svh"

// One counted comparison
`define CHK(what, exp, got) \
  n_checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
  end

module timer_flag_and_bus_access_test;
  typedef struct packed {
    logic [4:0]  a;
    logic [1:0]  b;
    logic [15:0] d;
    logic [15:0] e;
  } tfab_row_t;

  logic        clock, rst, pin, wr_stb, rd_stb, sel;
  logic [4:0]  addr;
  logic [1:0]  be;
  logic [15:0] wdata, rdata, v;
  logic        dma_req, clr_cap, clr_mat, cm, irq;
  int          bad_count = 0;
  int          n_checks = 0;
  int          k;

  // Write, read back: word, byte-lane and read-only cases
  tfab_row_t rows [18] = '{
    '{5'h02, 2'h3, 16'h007f, 16'h007f}, '{5'h08, 2'h3, 16'h1234, 16'h1234},
    '{5'h08, 2'h1, 16'h00ff, 16'h1234}, '{5'h09, 2'h3, 16'h5678, 16'h5678},
    '{5'h0a, 2'h3, 16'hffff, 16'hffff}, '{5'h0b, 2'h3, 16'habcd, 16'h0000},
    '{5'h07, 2'h3, 16'h0010, 16'h0010}, '{5'h0d, 2'h2, 16'hfc00, 16'hfc00},
    '{5'h0d, 2'h1, 16'h00f0, 16'hfcf0}, '{5'h0d, 2'h3, 16'h0000, 16'h0000},
    '{5'h0e, 2'h1, 16'h00ff, 16'h0000}, '{5'h0e, 2'h2, 16'hfe00, 16'hfe00},
    '{5'h0f, 2'h3, 16'h0300, 16'h0000}, '{5'h0f, 2'h2, 16'h0000, 16'h0000},
    '{5'h10, 2'h2, 16'h0f00, 16'h0f00}, '{5'h06, 2'h3, 16'h1111, 16'h0000},
    '{5'h1f, 2'h3, 16'hffff, 16'h0000}, '{5'h0c, 2'h3, 16'h0005, 16'h0005}};

  tfab_core tfab_core_i (
    .i_clock(clock), .i_rst(rst), .i_addr(addr), .i_be(be),
    .i_wdata(wdata), .i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(rdata),
    .i_capture_pin(pin), .o_dma_req(dma_req),
    .i_dma_clr_capture(clr_cap), .i_dma_clr_match(clr_mat),
    .o_compare_match(cm), .o_irq(irq)
  );
  tfab_dma_model tfab_dma_model_i (
    .i_clock(clock), .i_rst(rst), .i_dma_req(dma_req), .i_sel(sel),
    .o_clr_capture(clr_cap), .o_clr_match(clr_mat)
  );

  // Clock
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // One-cycle write strobe
  task automatic bus_wr(input logic [4:0] a, input logic [1:0] b,
                        input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    be <= b;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clock);
    wr_stb <= 1'h0;
  endtask

  // Read data is taken in the one cycle after the strobe
  task automatic bus_rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clock);
    rd_stb <= 1'h0;
    #1 d = rdata;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    wrap_up();
  end

  initial begin
    rst = 1'h1;
    pin = 1'h0;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    sel = 1'h0;
    addr = 5'h00;
    be = 2'h0;
    wdata = 16'h0000;
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    // Reset values
    for (k = 8; k < 11; k++) begin
      bus_rd(5'(k), v);
      `CHK("compare reset", 16'hffff, v)
    end
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("status reset", 16'h0000, v)
    foreach (rows[i]) begin
      bus_wr(rows[i].a, rows[i].b, rows[i].d);
      bus_rd(rows[i].a, v);
      `CHK("register row", rows[i].e, v)
    end
    // Counter zero wraps with its interrupt masked
    bus_wr(`TFAB_A_IRQ_MASK, 2'h3, 16'h0000);
    bus_wr(`TFAB_A_CNT0_HI, 2'h3, 16'hffff);
    bus_wr(`TFAB_A_CNT0_LO, 2'h3, 16'hfffd);
    bus_wr(`TFAB_A_START12, 2'h2, 16'h0100);
    repeat (8) @(posedge clock);
    bus_wr(`TFAB_A_START12, 2'h2, 16'h0000);
    #1 `CHK("masked irq", 1'h0, irq)
    bus_wr(`TFAB_A_STATUS, 2'h3, 16'h0000);
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("overflow kept", 1'h1, v[3])
    bus_wr(`TFAB_A_STATUS, 2'h3, 16'h0000);
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("overflow cleared", 1'h0, v[3])
    bus_wr(`TFAB_A_IRQ_MASK, 2'h3, 16'h0008);
    @(posedge clock);
    #1 `CHK("irq raised", 1'h1, irq)
    bus_rd(`TFAB_A_IRQ_STAT, v);
    `CHK("irq status", 1'h1, v[3])
    bus_rd(`TFAB_A_IRQ_STAT, v);
    `CHK("irq status read clear", 16'h0000, v)
    #1 `CHK("irq dropped", 1'h0, irq)
    // Interval flag on bit 10 rising
    bus_wr(`TFAB_A_CNT0_HI, 2'h3, 16'h0000);
    bus_wr(`TFAB_A_CNT0_LO, 2'h3, 16'h03fc);
    bus_wr(`TFAB_A_START12, 2'h2, 16'h0100);
    repeat (10) @(posedge clock);
    bus_wr(`TFAB_A_START12, 2'h2, 16'h0000);
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("interval flag", 1'h1, v[5])
    // Split 32-bit write, then split read
    bus_wr(`TFAB_A_CNT0_HI, 2'h3, 16'h0001);
    bus_wr(`TFAB_A_CNT0_LO, 2'h3, 16'h2345);
    bus_rd(`TFAB_A_CNT0_HI, v);
    `CHK("counter upper", 16'h0001, v)
    bus_rd(`TFAB_A_CNT0_LO, v);
    `CHK("counter lower", 16'h2345, v)
    // Capture, then DMA clears its flag
    @(posedge clock);
    pin <= 1'h1;
    k = 0;
    while (dma_req !== 1'h1 && k < 20) begin
      @(posedge clock);
      #1 k++;
    end
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("capture flags", 3'h5, {v[2], v[1], v[0]})
    @(posedge clock);
    pin <= 1'h0;
    repeat (12) @(posedge clock);
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("dma capture clear", 2'h2, {v[2], v[0]})
    bus_rd(`TFAB_A_CAP_HI, v);
    `CHK("capture upper", 16'h0001, v)
    bus_rd(`TFAB_A_CAP_LO, v);
    `CHK("capture lower", 16'h2345, v)
    // Compare match on counter one
    @(posedge clock);
    sel <= 1'h1;
    bus_wr(`TFAB_A_CNT1, 2'h3, 16'h0000);
    bus_wr(`TFAB_A_OCR, 2'h3, 16'h0008);
    bus_wr(`TFAB_A_START12, 2'h2, 16'h0200);
    k = 0;
    while (cm !== 1'h1 && k < 40) begin
      @(posedge clock);
      #1 k++;
    end
    `CHK("match pulse", 1'h1, cm)
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("match flag", 1'h1, v[1])
    bus_wr(`TFAB_A_START12, 2'h2, 16'h0000);
    repeat (12) @(posedge clock);
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("dma match clear", 1'h0, v[1])
    // Down-counter reaches zero and holds
    bus_wr(`TFAB_A_DOWN_COUNTER, 2'h3, 16'h0002);
    bus_wr(`TFAB_A_START3, 2'h2, 16'h0100);
    repeat (10) @(posedge clock);
    bus_rd(`TFAB_A_DOWN_COUNTER, v);
    `CHK("down count held", 16'h0000, v)
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("underflow flag", 1'h1, v[4])
    // Counter one meets the general register: down-counter cut off
    bus_wr(`TFAB_A_START12, 2'h2, 16'h0200);
    repeat (8) @(posedge clock);
    bus_wr(`TFAB_A_START12, 2'h2, 16'h0000);
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("underflow cleared", 1'h0, v[4])
    // Reset in mid-run restores compare and flag values
    @(posedge clock);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    bus_rd(`TFAB_A_GEN, v);
    `CHK("gen after reset", 16'hffff, v)
    bus_rd(`TFAB_A_STATUS, v);
    `CHK("status after reset", 16'h0000, v)
    wrap_up();
  end
endmodule // timer_flag_and_bus_access_test

`default_nettype wire
